// File: tb_top.sv
// self-checking bench for the touch-probe latch
`timescale 1ns/1ps
`default_nettype none
`include "tpl_defines.svh"
module tb_top;
  import tpl_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] probe_ctrl = 16'h0000;
  tpl_od_req_t od_req = '0;
  tpl_od_rsp_t od_rsp;
  logic [1:0]  probe_in;
  logic        enc_index;
  logic [31:0] pos_fb;
  logic [15:0] status;
  logic [31:0] accel_limit;
  logic [31:0] decel_limit;
  int          failures = 0;
  int          n_checks = 0;
  always #5 clk_sys = ~clk_sys;
  tpl_probe_model i_model (.CLK_SYS(clk_sys), .PROBE_IN(probe_in), .ENC_INDEX(enc_index),
    .POS_FB(pos_fb));
  tpl_touch_probe i_dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .PROBE_IN(probe_in),
    .ENC_INDEX(enc_index), .POS_FB(pos_fb), .PROBE_CTRL(probe_ctrl), .OD_REQ(od_req),
    .OD_RSP(od_rsp), .STATUS(status), .ACCEL_LIMIT(accel_limit), .DECEL_LIMIT(decel_limit));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one-cycle request pulse; answer stands in the cycle after the taking edge
  task automatic od(input logic w, input logic [15:0] idx, input logic [31:0] wd,
                    input logic [31:0] exp, input logic err);
    @(posedge clk_sys);
    od_req <= '{rd: !w, wr: w, index: idx, wdata: wd};
    @(posedge clk_sys);
    od_req <= '0;
    #1;
    chk(od_rsp.ack, 1'b1);
    chk(od_rsp.err, err);
    if (!w)
      chk(od_rsp.rdata, exp);
  endtask : od
  task automatic set_ctrl(input logic [15:0] v);
    @(posedge clk_sys);
    probe_ctrl <= v;
    repeat (3) @(posedge clk_sys);
  endtask : set_ctrl
  task automatic t_reset;
    od(0, `TPL_IDX_STATUS, 0, 0, 0);
    od(0, `TPL_IDX_P1_RISE, 0, 0, 0);
    od(0, `TPL_IDX_P1_FALL, 0, 0, 0);
    od(0, `TPL_IDX_P2_RISE, 0, 0, 0);
    od(0, `TPL_IDX_P2_FALL, 0, 0, 0);
    od(0, `TPL_IDX_ACCEL, 0, `TPL_LIMIT_RST, 0);
    od(0, `TPL_IDX_DECEL, 0, `TPL_LIMIT_RST, 0);
    od(0, `TPL_IDX_P1_RCNT, 0, 0, 0);
    od(0, `TPL_IDX_P1_FCNT, 0, 0, 0);
    od(0, 16'h6000, 0, 0, 1);
    chk(status, 0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_limits;
    od(1, `TPL_IDX_ACCEL, 32'h00000000, 0, 1);
    od(1, `TPL_IDX_ACCEL, 32'h80000000, 0, 1);
    od(1, `TPL_IDX_ACCEL, 32'h00000001, 0, 0);
    od(1, `TPL_IDX_DECEL, 32'h7FFFFFFF, 0, 0);
    od(1, `TPL_IDX_DECEL, 32'h00000000, 0, 1);
    od(1, `TPL_IDX_P1_RISE, 32'h00000005, 0, 1);
    od(0, `TPL_IDX_ACCEL, 0, 32'h00000001, 0);
    od(0, `TPL_IDX_DECEL, 0, 32'h7FFFFFFF, 0);
    od(0, `TPL_IDX_P1_RISE, 0, 0, 0);
    chk(accel_limit, 32'h00000001);
    chk(decel_limit, 32'h7FFFFFFF);
    $display("test limits done");
  endtask : t_limits
  task automatic t_p1_cont;
    set_ctrl(16'h0033);
    i_model.move(0, 1'b1, 32'h80000001);
    od(0, `TPL_IDX_P1_RISE, 0, 32'h80000001, 0);
    od(0, `TPL_IDX_STATUS, 0, 32'h00000003, 0);
    i_model.move(0, 1'b0, 32'h00001234);
    od(0, `TPL_IDX_P1_FALL, 0, 32'h00001234, 0);
    i_model.move(0, 1'b1, 32'h7FFFFFFF);
    od(0, `TPL_IDX_P1_RISE, 0, 32'h7FFFFFFF, 0);
    od(0, `TPL_IDX_P1_RCNT, 0, 32'h00000002, 0);
    od(0, `TPL_IDX_P1_FCNT, 0, 32'h00000001, 0);
    i_model.move(0, 1'b0, 32'h00000000);
    chk(status, 16'h0007);
    $display("test probe one continuous done");
  endtask : t_p1_cont
  task automatic t_p2_single;
    set_ctrl(16'h3100);
    i_model.move(1, 1'b1, 32'h0000AAAA);
    chk(status, 16'h0300);
    i_model.move(1, 1'b0, 32'h0000BBBB);
    i_model.move(1, 1'b1, 32'h0000CCCC);
    i_model.move(1, 1'b0, 32'h0000DDDD);
    od(0, `TPL_IDX_P2_RISE, 0, 32'h0000AAAA, 0);
    od(0, `TPL_IDX_P2_FALL, 0, 32'h0000BBBB, 0);
    od(0, `TPL_IDX_STATUS, 0, 32'h00000700, 0);
    od(0, `TPL_IDX_P1_RCNT, 0, 32'h00000002, 0);
    $display("test probe two single done");
  endtask : t_p2_single
  task automatic t_source;
    set_ctrl(16'h0000);
    set_ctrl(16'h0015);
    i_model.move(0, 1'b1, 32'h00000E0E);
    i_model.move(0, 1'b0, 32'h00000E0F);
    od(0, `TPL_IDX_P1_RISE, 0, 32'h7FFFFFFF, 0);
    chk(status, 16'h0001);
    i_model.move(2, 1'b1, 32'hFFFFF000);
    i_model.move(2, 1'b0, 32'h00000001);
    od(0, `TPL_IDX_P1_RISE, 0, 32'hFFFFF000, 0);
    od(0, `TPL_IDX_P1_RCNT, 0, 32'h00000003, 0);
    chk(status, 16'h0003);
    $display("test source select done");
  endtask : t_source
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_limits();
    t_p1_cont();
    t_p2_single();
    t_source();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire

// File: tpl_defines.svh
// object indexes, bit positions, reset values and limits of the touch-probe latch
`ifndef TPL_DEFINES_SVH
`define TPL_DEFINES_SVH

`define TPL_IDX_STATUS     16'h60B9
`define TPL_IDX_P1_RISE    16'h60BA
`define TPL_IDX_P1_FALL    16'h60BB
`define TPL_IDX_P2_RISE    16'h60BC
`define TPL_IDX_P2_FALL    16'h60BD
`define TPL_IDX_ACCEL      16'h60C5
`define TPL_IDX_DECEL      16'h60C6
`define TPL_IDX_P1_RCNT    16'h60D5
`define TPL_IDX_P1_FCNT    16'h60D6

`define TPL_CTL_EN         0
`define TPL_CTL_MODE       1
`define TPL_CTL_SRC        2
`define TPL_CTL_RISE_EN    4
`define TPL_PROBE_STRIDE   8

`define TPL_ST_EN          0
`define TPL_ST_RISE        1
`define TPL_ST_RSVD_MASK   16'hF8F8

`define TPL_LIMIT_RST      32'h05F5E100
`define TPL_LIMIT_MIN      32'h00000001
`define TPL_LIMIT_MAX      32'h7FFFFFFF

`endif

// File: tpl_pin_sync.sv
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module tpl_pin_sync (
  input  wire logic CLK_SYS,
  input  wire logic RST_N,
  input  wire logic PIN,
  output logic      RISE,
  output logic      FALL
);
  import tpl_pkg::*;

  tpl_sync_t st;
  tpl_sync_t next_st;

  always_comb
  begin
    next_st      = st;
    next_st.s1   = PIN;
    next_st.s2   = st.s1;
    next_st.s3   = st.s2;
    // a change only counts once stages two and three agree
    if (st.s2 == st.s3)
    begin
      next_st.lvl = st.s3;
    end
    next_st.rise = next_st.lvl & ~st.lvl;
    next_st.fall = ~next_st.lvl & st.lvl;
  end

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign RISE = st.rise;
  assign FALL = st.fall;

endmodule : tpl_pin_sync
`default_nettype wire

// File: tpl_pkg.sv
// types shared by the touch-probe latch modules
package tpl_pkg;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] index;
    logic [31:0] wdata;
  } tpl_od_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } tpl_od_rsp_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic rise;
    logic fall;
  } tpl_sync_t;

  typedef struct packed {
    logic [3:0][31:0] pos;
    logic [3:0]       flag;
    logic [1:0]       en;
    logic [15:0]      cnt_rise1;
    logic [15:0]      cnt_fall1;
    logic [31:0]      acc;
    logic [31:0]      dec;
    tpl_od_rsp_t      rsp;
    logic [15:0]      status;
  } tpl_state_t;

endpackage : tpl_pkg

// File: tpl_probe_model.sv
// probe pins, index pulse and position feedback seen by the latch
`timescale 1ns/1ps
`default_nettype none
module tpl_probe_model (
  input  wire logic  CLK_SYS,
  output logic [1:0] PROBE_IN,
  output logic       ENC_INDEX,
  output logic [31:0] POS_FB
);
  initial
  begin
    PROBE_IN  = 2'h0;
    ENC_INDEX = 1'b0;
    POS_FB    = 32'h00000000;
  end
  // position held across the edge so the latched value is unambiguous
  task automatic move(input int ch, input logic v, input logic [31:0] pos);
    @(posedge CLK_SYS);
    POS_FB <= pos;
    if (ch == 2)
      ENC_INDEX <= v;
    else
      PROBE_IN[ch] <= v;
    // 5 edges to settle plus margin keeps edges well apart
    repeat (8) @(posedge CLK_SYS);
    // step off the edge so the caller reads settled outputs
    #1;
  endtask : move
endmodule : tpl_probe_model
`default_nettype wire

// File: tpl_touch_probe.sv
// touch-probe position latch with acceleration and deceleration limit objects
`timescale 1ns/1ps
`default_nettype none
`include "tpl_defines.svh"

// Operation
// - status bits 1,2 and 9,10 flag latched rising/falling edges of probes one, two
// - probe one rising edge captures position feedback into an unsigned 32-bit register
// - probe one falling edge captures position feedback into its own register
// - probe two rising edge captures position feedback into its own register
// - probe two falling edge captures position feedback into a fourth register
// - count latched probe one rising edges in 16 bits, zero after reset
// - writable acceleration limit, range 1 to 2147483647, default 100000000
// - writable deceleration limit, range 1 to 2147483647, default 100000000
// - single mode latches only the first trigger; continuous mode latches every trigger
// - per-probe source bit picks the probe input (0) or encoder index (1)
// - count latched probe one falling edges in 16 bits
module tpl_touch_probe (
  input  wire logic                 CLK_SYS,
  input  wire logic                 RST_N,
  input  wire logic [1:0]           PROBE_IN,
  input  wire logic                 ENC_INDEX,
  input  wire logic [31:0]          POS_FB,
  input  wire logic [15:0]          PROBE_CTRL,
  input  wire tpl_pkg::tpl_od_req_t OD_REQ,
  output tpl_pkg::tpl_od_rsp_t      OD_RSP,
  output logic [15:0]               STATUS,
  output logic [31:0]               ACCEL_LIMIT,
  output logic [31:0]               DECEL_LIMIT
);
  import tpl_pkg::*;

  tpl_state_t st;
  tpl_state_t next_st;
  logic [2:0] pin_raw;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;
  logic [3:0] lat;

  function automatic logic idx_known(input logic [15:0] idx);
    case (idx)
      `TPL_IDX_STATUS, `TPL_IDX_P1_RISE, `TPL_IDX_P1_FALL, `TPL_IDX_P2_RISE,
      `TPL_IDX_P2_FALL, `TPL_IDX_ACCEL, `TPL_IDX_DECEL, `TPL_IDX_P1_RCNT,
      `TPL_IDX_P1_FCNT: idx_known = 1'b1;
      default:          idx_known = 1'b0;
    endcase
  endfunction : idx_known

  function automatic logic limit_ok(input logic [31:0] val);
    limit_ok = (val >= `TPL_LIMIT_MIN) && (val <= `TPL_LIMIT_MAX);
  endfunction : limit_ok

  // pins 0,1 are the probes, pin 2 the encoder index
  // packed so every loop pass selects a pin that exists
  assign pin_raw = {ENC_INDEX, PROBE_IN};

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_sync
      tpl_pin_sync u_sync (
        .CLK_SYS (CLK_SYS),
        .RST_N   (RST_N),
        .PIN     (pin_raw[g]),
        .RISE    (pin_rise[g]),
        .FALL    (pin_fall[g])
      );
    end
  endgenerate

  // index i = probe*2 + edge, edge 0 rising, 1 falling
  generate
    for (g = 0; g < 4; g++)
    begin : g_lat
      localparam int P = g / 2;
      localparam int E = g % 2;
      localparam int B = P * `TPL_PROBE_STRIDE;
      logic sel_idx;
      logic edge_seen;
      assign sel_idx   = PROBE_CTRL[B + `TPL_CTL_SRC];
      // edges are found per pin ahead of the source mux, so switching source alone never latches
      assign edge_seen = sel_idx ? (E == 0 ? pin_rise[2] : pin_fall[2])
                                 : (E == 0 ? pin_rise[P] : pin_fall[P]);
      assign lat[g] = PROBE_CTRL[B + `TPL_CTL_EN] & PROBE_CTRL[B + `TPL_CTL_RISE_EN + E]
                    & edge_seen
                    & (PROBE_CTRL[B + `TPL_CTL_MODE] | ~st.flag[g]);
    end
  endgenerate

  always_comb
  begin
    next_st     = st;
    next_st.rsp = '0;
    for (int p = 0; p < 2; p++)
    begin
      next_st.en[p] = PROBE_CTRL[p * `TPL_PROBE_STRIDE + `TPL_CTL_EN];
    end
    for (int i = 0; i < 4; i++)
    begin
      if (lat[i])
      begin
        next_st.pos[i]  = POS_FB;
        next_st.flag[i] = 1'b1;
      end
      else if (!PROBE_CTRL[(i / 2) * `TPL_PROBE_STRIDE + `TPL_CTL_EN])
      begin
        // disabling a probe re-arms single mode
        next_st.flag[i] = 1'b0;
      end
    end
    if (lat[0])
    begin
      next_st.cnt_rise1 = st.cnt_rise1 + 16'h0001;
    end
    if (lat[1])
    begin
      next_st.cnt_fall1 = st.cnt_fall1 + 16'h0001;
    end
    if (OD_REQ.wr)
    begin
      next_st.rsp.ack = 1'b1;
      // out-of-range and read-only writes are dropped and flagged
      if (OD_REQ.index == `TPL_IDX_ACCEL && limit_ok(OD_REQ.wdata))
      begin
        next_st.acc = OD_REQ.wdata;
      end
      else if (OD_REQ.index == `TPL_IDX_DECEL && limit_ok(OD_REQ.wdata))
      begin
        next_st.dec = OD_REQ.wdata;
      end
      else
      begin
        next_st.rsp.err = 1'b1;
      end
    end
    else if (OD_REQ.rd)
    begin
      next_st.rsp.ack = 1'b1;
      next_st.rsp.err = ~idx_known(OD_REQ.index);
      case (OD_REQ.index)
        `TPL_IDX_STATUS:  next_st.rsp.rdata = {16'h0000, st.status};
        `TPL_IDX_P1_RISE: next_st.rsp.rdata = st.pos[0];
        `TPL_IDX_P1_FALL: next_st.rsp.rdata = st.pos[1];
        `TPL_IDX_P2_RISE: next_st.rsp.rdata = st.pos[2];
        `TPL_IDX_P2_FALL: next_st.rsp.rdata = st.pos[3];
        `TPL_IDX_ACCEL:   next_st.rsp.rdata = st.acc;
        `TPL_IDX_DECEL:   next_st.rsp.rdata = st.dec;
        `TPL_IDX_P1_RCNT: next_st.rsp.rdata = {16'h0000, st.cnt_rise1};
        `TPL_IDX_P1_FCNT: next_st.rsp.rdata = {16'h0000, st.cnt_fall1};
        default:          next_st.rsp.rdata = 32'h00000000;
      endcase
    end
    next_st.status = 16'h0000;
    for (int p = 0; p < 2; p++)
    begin
      next_st.status[p * `TPL_PROBE_STRIDE + `TPL_ST_EN]       = next_st.en[p];
      next_st.status[p * `TPL_PROBE_STRIDE + `TPL_ST_RISE]     = next_st.flag[p * 2];
      next_st.status[p * `TPL_PROBE_STRIDE + `TPL_ST_RISE + 1] = next_st.flag[p * 2 + 1];
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st     <= '0;
      st.acc <= `TPL_LIMIT_RST;
      st.dec <= `TPL_LIMIT_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign OD_RSP      = st.rsp;
  assign STATUS      = st.status;
  assign ACCEL_LIMIT = st.acc;
  assign DECEL_LIMIT = st.dec;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  generate
    for (g = 0; g < 4; g++)
    begin : g_chk
      property p_capture;
        lat[g] |=> (st.pos[g] == $past(POS_FB)) && st.flag[g];
      endproperty
      a_capture: assert property (p_capture)
        else $error("edge latch did not capture position");

      property p_single;
        (!PROBE_CTRL[(g / 2) * `TPL_PROBE_STRIDE + `TPL_CTL_MODE] && st.flag[g])
          |=> st.pos[g] == $past(st.pos[g]);
      endproperty
      a_single: assert property (p_single)
        else $error("single mode latched a second trigger");
    end
  endgenerate

  property p_rise_count;
    lat[0] |=> st.cnt_rise1 == $past(st.cnt_rise1) + 16'h0001;
  endproperty
  a_rise_count: assert property (p_rise_count)
    else $error("probe one rise counter did not advance");

  property p_fall_count;
    lat[1] |=> st.cnt_fall1 == $past(st.cnt_fall1) + 16'h0001;
  endproperty
  a_fall_count: assert property (p_fall_count)
    else $error("probe one fall counter did not advance");

  property p_status_flag;
    $rose(STATUS[9]) |-> $past(lat[2]);
  endproperty
  a_status_flag: assert property (p_status_flag)
    else $error("probe two rise flag set without a latch");

  property p_status_en;
    ##1 (STATUS[0] == $past(PROBE_CTRL[0])) && (STATUS[8] == $past(PROBE_CTRL[8]))
      && ((STATUS & `TPL_ST_RSVD_MASK) == 16'h0000);
  endproperty
  a_status_en: assert property (p_status_en)
    else $error("status enable or reserved bits wrong");

  property p_accel_wr;
    (OD_REQ.wr && OD_REQ.index == `TPL_IDX_ACCEL && limit_ok(OD_REQ.wdata))
      |=> (ACCEL_LIMIT == $past(OD_REQ.wdata)) && OD_RSP.ack && !OD_RSP.err;
  endproperty
  a_accel_wr: assert property (p_accel_wr)
    else $error("acceleration limit write not taken");

  property p_decel_range;
    (OD_REQ.wr && OD_REQ.index == `TPL_IDX_DECEL && OD_REQ.wdata == 32'h00000000)
      |=> (DECEL_LIMIT == $past(DECEL_LIMIT)) && OD_RSP.err;
  endproperty
  a_decel_range: assert property (p_decel_range)
    else $error("out of range deceleration limit accepted");

endmodule : tpl_touch_probe
`default_nettype wire
